/* File: cal_pkg.sv */
// calibration constants, defaults and state types
package cal_pkg;
  // 16-bit variant
  localparam int           W16        = 16;
  localparam int           SHIFT16    = 16;
  localparam logic [15:0]  X_DEF16    = 16'h8000;
  localparam logic [15:0]  M_DEF16    = 16'hFFFF;
  localparam logic [15:0]  C_DEF16    = 16'h8000;
  localparam logic [15:0]  MID16      = 16'h8000;
  localparam logic [15:0]  MAX16      = 16'hFFFF;
  localparam int           OFS_MUL16  = 4;
  // 14-bit variant
  localparam int           SHIFT14    = 14;
  localparam logic [15:0]  X_DEF14    = 16'h2000;
  localparam logic [15:0]  M_DEF14    = 16'h3FFF;
  localparam logic [15:0]  C_DEF14    = 16'h2000;
  localparam logic [15:0]  MID14      = 16'h2000;
  localparam logic [15:0]  MAX14      = 16'h3FFF;
  // group offset dac default and twos-complement sign bits
  localparam logic [13:0]  OFS_DEF    = 14'h2000;
  localparam logic [15:0]  SIGN16     = 16'h8000;
  localparam logic [15:0]  SIGN14     = 16'h2000;
  // initialization sequence length
  localparam int           INIT_NS    = 300000;
  localparam int           CLK_NS     = 10;
  localparam int           INIT_CYC   = INIT_NS / CLK_NS;

  // recalculation sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DONE = 2'b11
  } calc_state_t;
endpackage : cal_pkg

/* File: cal_if.sv */
// operand and result bundle between control and arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface cal_if;
  logic [15:0] raw;
  logic [15:0] gain;
  logic [15:0] offset;
  logic        wide;
  logic [15:0] code;
  modport ctrl (output raw, output gain, output offset, output wide, input code);
  modport alu  (input raw, input gain, input offset, input wide, output code);
endinterface : cal_if
`default_nettype wire

/* File: cal_alu.sv */
// shared multiply-add unit computing one calibrated code
`timescale 1ns/1ps
`default_nettype none
module cal_alu (
  cal_if.alu bus
);
  // 16x17 product fits 33 bits; shift, add, subtract midscale in a 21-bit signed sum
  logic        [16:0] m_plus1;
  logic        [32:0] product;
  logic        [18:0] scaled;
  logic signed [20:0] sum;
  logic signed [20:0] hi;

  assign m_plus1 = {1'b0, bus.gain} + 17'h00001;
  assign product = {17'h00000, bus.raw} * {16'h0000, m_plus1};
  // truncating shift by 16 or 14
  assign scaled  = bus.wide ? {2'b00, product[32:16]} : product[32:14];
  assign sum     = $signed({2'b00, scaled}) + $signed({5'h00, bus.offset})
                 - $signed({5'h00, (bus.wide ? cal_pkg::MID16 : cal_pkg::MID14)});
  assign hi      = $signed({5'h00, (bus.wide ? cal_pkg::MAX16 : cal_pkg::MAX14)});
  // out-of-range results clamp instead of wrapping
  assign bus.code = (sum < 0) ? 16'h0000 : (sum > hi) ? hi[15:0] : sum[15:0];
endmodule : cal_alu
`default_nettype wire

/* File: dac_gain_offset_calibration.sv */
// per-channel gain/offset calibration with output hold control
// Operation
// - 16-bit code is raw times (gain plus one) over 65536 plus offset minus 32768.
// - 16-bit defaults are raw 32768, gain all ones and offset 32768.
// - in 16-bit mode the 14-bit group offset is scaled by four before comparison.
// - the group offset code powers up at 8192.
// - 14-bit code is raw times (gain plus one) over 16384 plus offset minus 8192, with 8192/ones/8192 defaults.
// - at power-up outputs are disconnected, tied to signal ground, loop closed.
// - while clear is low outputs stay disconnected but programming is accepted.
// - with clear high, outputs connect after initialization completes.
// - any raw, gain or offset write recalculates the A or B word chosen by the global select.
// - twos-complement select affects raw, offset trim and group offset only.
`timescale 1ns/1ps
`default_nettype none
module dac_gain_offset_calibration (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // variant and data format
  input  wire logic        wide_mode_i,
  input  wire logic        twos_complement_select_i,
  input  wire logic        ab_select_i,
  // trim writes
  input  wire logic        raw_wr_i,
  input  wire logic        gain_wr_i,
  input  wire logic        offset_wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        group_ofs_wr_i,
  input  wire logic [13:0] group_ofs_i,
  // output control
  input  wire logic        output_clear_n_i,
  // results
  output logic      [15:0] calibrated_word_a_o,
  output logic      [15:0] calibrated_word_b_o,
  output logic      [17:0] group_ofs_aligned_o,
  output logic signed [18:0] code_minus_ofs_o,
  output logic             busy_o,
  output logic             init_done_o,
  output logic             out_connect_o,
  output logic             signal_ground_level_o,
  output logic             loop_closed_o
);
  // ----------------------------------------------------------------
  // trim registers
  // ----------------------------------------------------------------
  logic [15:0] raw_word_a_reg;
  logic [15:0] raw_word_b_reg;
  logic [15:0] gain_reg;
  logic [15:0] offset_reg;
  logic [13:0] group_ofs_reg;
  logic        target_b_reg;
  logic [15:0] wdata_bin;
  logic [13:0] group_ofs_bin;
  logic [15:0] sign_bit;
  logic        any_wr;
  logic        def_pending_reg;

  // twos complement just flips the msb into offset binary
  assign sign_bit      = wide_mode_i ? cal_pkg::SIGN16 : cal_pkg::SIGN14;
  assign wdata_bin     = twos_complement_select_i ? (wdata_i ^ sign_bit) : wdata_i;
  assign group_ofs_bin = twos_complement_select_i ? (group_ofs_i ^ 14'h2000) : group_ofs_i;
  assign any_wr        = raw_wr_i | gain_wr_i | offset_wr_i;

  // variant defaults are loaded once after reset release, keeping the reset path constant
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      def_pending_reg <= 1'b1;
    end else begin
      def_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_word_a_reg <= cal_pkg::X_DEF16;
      raw_word_b_reg <= cal_pkg::X_DEF16;
      gain_reg       <= cal_pkg::M_DEF16;
      offset_reg     <= cal_pkg::C_DEF16;
    end else if (def_pending_reg) begin
      raw_word_a_reg <= wide_mode_i ? cal_pkg::X_DEF16 : cal_pkg::X_DEF14;
      raw_word_b_reg <= wide_mode_i ? cal_pkg::X_DEF16 : cal_pkg::X_DEF14;
      gain_reg       <= wide_mode_i ? cal_pkg::M_DEF16 : cal_pkg::M_DEF14;
      offset_reg     <= wide_mode_i ? cal_pkg::C_DEF16 : cal_pkg::C_DEF14;
    end else begin
      if (raw_wr_i && !ab_select_i) raw_word_a_reg <= wdata_bin;
      if (raw_wr_i &&  ab_select_i) raw_word_b_reg <= wdata_bin;
      if (gain_wr_i)   gain_reg   <= wdata_i;
      if (offset_wr_i) offset_reg <= wdata_bin;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      group_ofs_reg <= cal_pkg::OFS_DEF;
    end else if (group_ofs_wr_i) begin
      group_ofs_reg <= group_ofs_bin;
    end
  end

  // ----------------------------------------------------------------
  // recalculation sequencer
  // ----------------------------------------------------------------
  cal_pkg::calc_state_t state_reg;
  cal_pkg::calc_state_t state_next;
  cal_if                alu_bus ();

  assign alu_bus.raw    = target_b_reg ? raw_word_b_reg : raw_word_a_reg;
  assign alu_bus.gain   = gain_reg;
  assign alu_bus.offset = offset_reg;
  assign alu_bus.wide   = wide_mode_i;

  cal_alu i_cal_alu (
    .bus (alu_bus.alu)
  );

  logic both_reg;

  // a write during a calculation restarts it so the latest trims win
  // after reset the A word is computed first, then a second pass computes B
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cal_pkg::ST_IDLE: if (any_wr || def_pending_reg) state_next = cal_pkg::ST_CALC;
      cal_pkg::ST_CALC: state_next = (any_wr || (both_reg && !target_b_reg)) ? cal_pkg::ST_CALC : cal_pkg::ST_DONE;
      cal_pkg::ST_DONE: state_next = any_wr ? cal_pkg::ST_CALC : cal_pkg::ST_IDLE;
      default:          state_next = cal_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg    <= cal_pkg::ST_IDLE;
      target_b_reg <= 1'b0;
      both_reg     <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (any_wr) begin
        target_b_reg <= ab_select_i;
        both_reg     <= 1'b0;
      end else if (state_reg == cal_pkg::ST_CALC && both_reg && !target_b_reg) begin
        target_b_reg <= 1'b1;
      end
    end
  end

  // results land while the sequencer sits in ST_CALC with no newer write pending
  logic result_load;
  assign result_load = (state_reg == cal_pkg::ST_CALC) && !any_wr;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      calibrated_word_a_o <= cal_pkg::MID16;
      calibrated_word_b_o <= cal_pkg::MID16;
    end else if (result_load) begin
      if (!target_b_reg) calibrated_word_a_o <= alu_bus.code;
      if ( target_b_reg) calibrated_word_b_o <= alu_bus.code;
    end
  end

  assign busy_o = (state_reg != cal_pkg::ST_IDLE) || def_pending_reg;

  // ----------------------------------------------------------------
  // group offset alignment
  // ----------------------------------------------------------------
  logic [17:0] ofs_aligned;
  logic [15:0] sel_code;
  assign ofs_aligned = wide_mode_i ? ({4'h0, group_ofs_reg} * 18'(cal_pkg::OFS_MUL16))
                                   : {4'h0, group_ofs_reg};
  assign sel_code    = ab_select_i ? calibrated_word_b_o : calibrated_word_a_o;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      group_ofs_aligned_o <= 18'h00000;
      code_minus_ofs_o    <= 19'sh00000;
    end else begin
      group_ofs_aligned_o <= ofs_aligned;
      code_minus_ofs_o    <= $signed({3'b000, sel_code}) - $signed({1'b0, ofs_aligned});
    end
  end

  // ----------------------------------------------------------------
  // power-up output hold
  // ----------------------------------------------------------------
  logic [15:0] init_cnt_reg;
  logic        connect_next;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_cnt_reg <= 16'h0000;
      init_done_o  <= 1'b0;
    end else if (!init_done_o) begin
      init_cnt_reg <= init_cnt_reg + 16'h0001;
      init_done_o  <= (init_cnt_reg == 16'(cal_pkg::INIT_CYC - 1));
    end
  end

  // clear low holds the pins at ground but trim writes above are never blocked
  assign connect_next = init_done_o && output_clear_n_i;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_connect_o         <= 1'b0;
      signal_ground_level_o <= 1'b1;
    end else begin
      out_connect_o         <= connect_next;
      signal_ground_level_o <= !connect_next;
    end
  end

  // feedback loop stays closed whenever the output is detached
  assign loop_closed_o = 1'b1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_hold_till_init;
    @(posedge core_clk_i) disable iff (!rstn_i) !init_done_o |-> !out_connect_o;
  endproperty
  a_hold_till_init: assert property (p_hold_till_init) else $error("output connected before init");

  property p_clear_holds;
    @(posedge core_clk_i) disable iff (!rstn_i) !output_clear_n_i |=> !out_connect_o && signal_ground_level_o;
  endproperty
  a_clear_holds: assert property (p_clear_holds) else $error("output connected while clear low");

  property p_clear_release;
    @(posedge core_clk_i) disable iff (!rstn_i) init_done_o && output_clear_n_i |=> out_connect_o;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("output not connected after clear");

  property p_write_taken;
    @(posedge core_clk_i) disable iff (!rstn_i) gain_wr_i && !def_pending_reg |=> gain_reg == $past(wdata_i);
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("gain write lost");

  property p_recalc;
    @(posedge core_clk_i) disable iff (!rstn_i) any_wr ##1 !any_wr [*2] |-> state_reg == cal_pkg::ST_DONE;
  endproperty
  a_recalc: assert property (p_recalc) else $error("no recalculation after write");

  property p_ofs_scale;
    @(posedge core_clk_i) disable iff (!rstn_i) wide_mode_i |-> ofs_aligned == {group_ofs_reg, 2'b00};
  endproperty
  a_ofs_scale: assert property (p_ofs_scale) else $error("group offset not scaled by four");

  property p_range;
    @(posedge core_clk_i) disable iff (!rstn_i) !wide_mode_i |-> alu_bus.code <= cal_pkg::MAX14;
  endproperty
  a_range: assert property (p_range) else $error("narrow code out of range");

  property p_ofs_default;
    @(posedge core_clk_i) disable iff (!rstn_i) def_pending_reg |-> group_ofs_reg == cal_pkg::OFS_DEF;
  endproperty
  a_ofs_default: assert property (p_ofs_default) else $error("group offset default wrong");

  c_connect: cover property (@(posedge core_clk_i) disable iff (!rstn_i) $rose(out_connect_o));
  c_write_b: cover property (@(posedge core_clk_i) disable iff (!rstn_i) raw_wr_i && ab_select_i);
  c_clear:   cover property (@(posedge core_clk_i) disable iff (!rstn_i) $fell(output_clear_n_i));
endmodule : dac_gain_offset_calibration
`default_nettype wire

/* File: dac_gain_offset_calibration_test.sv */
// self-checking bench for the calibration arithmetic and output hold control
`timescale 1ns/1ps
`default_nettype none
module dac_gain_offset_calibration_test;
  // ----------------------------------------
  // signals and expected state
  // ----------------------------------------
  logic               core_clk_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic               wide_mode_i = 1'b1;
  logic               twos_complement_select_i = 1'b0;
  logic               ab_select_i = 1'b0;
  logic               raw_wr_i = 1'b0;
  logic               gain_wr_i = 1'b0;
  logic               offset_wr_i = 1'b0;
  logic        [15:0] wdata_i = 16'h0000;
  logic               group_ofs_wr_i = 1'b0;
  logic        [13:0] group_ofs_i = 14'h0000;
  logic               output_clear_n_i = 1'b0;
  logic        [15:0] calibrated_word_a_o;
  logic        [15:0] calibrated_word_b_o;
  logic        [17:0] group_ofs_aligned_o;
  logic signed [18:0] code_minus_ofs_o;
  logic               busy_o;
  logic               init_done_o;
  logic               out_connect_o;
  logic               signal_ground_level_o;
  logic               loop_closed_o;
  int                 err_count = 0;
  int                 n_compared = 0;
  logic        [15:0] raw_m [2];
  logic        [15:0] gain_m;
  logic        [15:0] off_m;
  logic        [13:0] ofs_m;
  logic        [15:0] word_m [2];

  always #5 core_clk_i = ~core_clk_i;

  dac_gain_offset_calibration i_dac_gain_offset_calibration (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wide_mode_i(wide_mode_i),
    .twos_complement_select_i(twos_complement_select_i), .ab_select_i(ab_select_i),
    .raw_wr_i(raw_wr_i), .gain_wr_i(gain_wr_i), .offset_wr_i(offset_wr_i), .wdata_i(wdata_i),
    .group_ofs_wr_i(group_ofs_wr_i), .group_ofs_i(group_ofs_i), .output_clear_n_i(output_clear_n_i),
    .calibrated_word_a_o(calibrated_word_a_o), .calibrated_word_b_o(calibrated_word_b_o),
    .group_ofs_aligned_o(group_ofs_aligned_o), .code_minus_ofs_o(code_minus_ofs_o), .busy_o(busy_o),
    .init_done_o(init_done_o), .out_connect_o(out_connect_o),
    .signal_ground_level_o(signal_ground_level_o), .loop_closed_o(loop_closed_o));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
      err_count++;
    end
  endtask : chk

  // truncating shift, out-of-range results pinned to the code limits
  function automatic logic [15:0] calc(input logic [15:0] x, input logic [15:0] m, input logic [15:0] c);
    longint v;
    if (wide_mode_i) v = ((longint'(x) * (longint'(m) + 1)) >> 16) + longint'(c) - 32768;
    else v = ((longint'(x) * (longint'(m) + 1)) >> 14) + longint'(c) - 8192;
    if (v < 0) v = 0;
    if (v > (wide_mode_i ? 65535 : 16383)) v = wide_mode_i ? 65535 : 16383;
    return v[15:0];
  endfunction : calc

  // sel 0: busy falls, sel 1: initialization done
  task automatic wait_for(input int sel, input int lim);
    int n = 0;
    while (((sel == 0) ? (busy_o !== 1'b0) : (init_done_o !== 1'b1)) && n < lim) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      $display("MISMATCH wait %0d expected done seen timeout", sel);
      err_count++;
      end_of_test();
    end
  endtask : wait_for

  task automatic chk_words;
    chk("word_a", {2'b00, word_m[0]}, {2'b00, calibrated_word_a_o});
    chk("word_b", {2'b00, word_m[1]}, {2'b00, calibrated_word_b_o});
  endtask : chk_words

  task automatic do_reset(input logic wide, input logic clr_n);
    rstn_i = 1'b0;
    wide_mode_i = wide;
    output_clear_n_i = clr_n;
    twos_complement_select_i = 1'b0;
    repeat (16) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    raw_m[0] = wide ? 16'h8000 : 16'h2000;
    raw_m[1] = raw_m[0];
    gain_m = wide ? 16'hFFFF : 16'h3FFF;
    off_m = raw_m[0];
    ofs_m = 14'h2000;
    word_m[0] = calc(raw_m[0], gain_m, off_m);
    word_m[1] = word_m[0];
    wait_for(0, 50);
  endtask : do_reset

  // kind 0 raw, 1 gain, 2 offset; gain never takes the sign flip
  task automatic wr(input int kind, input logic ab, input logic [15:0] d);
    logic [15:0] v;
    v = (kind != 1 && twos_complement_select_i) ? (d ^ (wide_mode_i ? 16'h8000 : 16'h2000)) : d;
    if (kind == 0) raw_m[ab] = v;
    if (kind == 1) gain_m = v;
    if (kind == 2) off_m = v;
    // only the word picked by the global select is recalculated
    word_m[ab] = calc(raw_m[ab], gain_m, off_m);
    ab_select_i = ab;
    wdata_i = d;
    raw_wr_i = (kind == 0);
    gain_wr_i = (kind == 1);
    offset_wr_i = (kind == 2);
    @(posedge core_clk_i);
    #1;
    {raw_wr_i, gain_wr_i, offset_wr_i} = 3'b000;
    chk("busy", 18'h1, {17'h0, busy_o});
    wait_for(0, 50);
    chk_words();
  endtask : wr

  task automatic gw(input logic [13:0] d);
    int e;
    ofs_m = twos_complement_select_i ? (d ^ 14'h2000) : d;
    group_ofs_i = d;
    group_ofs_wr_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    group_ofs_wr_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("group_ofs", wide_mode_i ? {ofs_m, 2'b00} : {4'h0, ofs_m}, group_ofs_aligned_o);
    e = int'(word_m[ab_select_i]) - (wide_mode_i ? int'(ofs_m) * 4 : int'(ofs_m));
    chk("code_minus_ofs", e[17:0], code_minus_ofs_o[17:0]);
  endtask : gw

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    chk_words();
    chk("group_ofs", wide_mode_i ? 18'h08000 : 18'h02000, group_ofs_aligned_o);
    chk("connect", 18'h0, {17'h0, out_connect_o});
    chk("ground", 18'h1, {17'h0, signal_ground_level_o});
    chk("loop", 18'h1, {17'h0, loop_closed_o});
    chk("init_done", 18'h0, {17'h0, init_done_o});
  endtask : t_defaults

  task automatic t_arith;
    wr(0, 1'b0, 16'h1234);
    wr(1, 1'b1, 16'hF000);
    wr(2, 1'b0, 16'h8062);
    wr(1, 1'b0, 16'hFF5B);
    wr(0, 1'b1, 16'hFFFF);
    wr(2, 1'b1, 16'hFFFF);
    wr(0, 1'b0, 16'h0000);
    wr(2, 1'b0, 16'h0000);
  endtask : t_arith

  task automatic t_clear;
    wait_for(1, 31000);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("connect", 18'h0, {17'h0, out_connect_o});
    output_clear_n_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("connect", 18'h1, {17'h0, out_connect_o});
    chk("ground", 18'h0, {17'h0, signal_ground_level_o});
    chk_words();
  endtask : t_clear

  task automatic t_twos;
    gw(14'h1000);
    twos_complement_select_i = 1'b1;
    gw(14'h0000);
    wr(1, 1'b0, 16'h7FFF);
    wr(2, 1'b0, 16'h0000);
    wr(0, 1'b0, 16'h0000);
  endtask : t_twos

  task automatic t_narrow;
    wr(0, 1'b0, 16'h3FFF);
    wr(2, 1'b1, 16'h0000);
    gw(14'h0123);
    wait_for(1, 31000);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("connect", 18'h1, {17'h0, out_connect_o});
  endtask : t_narrow

  initial begin
    do_reset(1'b1, 1'b0);
    t_defaults();
    t_arith();
    t_clear();
    t_twos();
    do_reset(1'b0, 1'b1);
    t_defaults();
    t_narrow();
    end_of_test();
  end
endmodule : dac_gain_offset_calibration_test
`default_nettype wire
